// ===== design/lcc_pkg.sv
// package for the light conversion control block
// assumes one 50 MHz clock and a synchronous active-high reset
`default_nettype none
package lcc_pkg;
	localparam logic [7:0] LCC_ADDR_RESULT = 8'h00;
	localparam logic [7:0] LCC_ADDR_SETUP = 8'h01;
	localparam logic [15:0] LCC_SETUP_RESET = 16'hc810;
	// field positions in conversion_setup
	localparam int LCC_RANGE_LSB = 12;
	localparam int LCC_LEN_BIT = 11;
	localparam int LCC_MODE_LSB = 9;
	localparam int LCC_OVF_BIT = 8;
	localparam int LCC_DONE_BIT = 7;
	localparam int LCC_ABOVE_BIT = 6;
	localparam int LCC_BELOW_BIT = 5;
	// writable bits: range, length, mode, latch, polarity, mask, fault count
	localparam logic [15:0] LCC_RW_MASK = 16'hfe1f;
	localparam logic [3:0] LCC_RANGE_AUTO = 4'hc;
	localparam logic [3:0] LCC_RANGE_MAX = 4'hb;
	localparam logic [1:0] LCC_MODE_OFF = 2'h0;
	localparam logic [1:0] LCC_MODE_SINGLE = 2'h1;
	// conversion times
	localparam int LCC_CLK_MHZ = 50;
	localparam int LCC_SHORT_MS = 100;
	localparam int LCC_LONG_MS = 800;
	localparam int LCC_SHORT_CYC = LCC_SHORT_MS * 1000 * LCC_CLK_MHZ;
	localparam int LCC_LONG_CYC = LCC_LONG_MS * 1000 * LCC_CLK_MHZ;
	// resolution loss in bits at the short time
	localparam logic [1:0] LCC_LOSS_ONE = 2'h1;
	localparam logic [1:0] LCC_LOSS_TWO = 2'h2;
	localparam logic [1:0] LCC_LOSS_THREE = 2'h3;
	localparam logic [3:0] LCC_RANGE_R5 = 4'h5;
	localparam logic [3:0] LCC_RANGE_R0 = 4'h0;
	typedef enum logic [1:0] {
		LCC_IDLE = 2'b01,
		LCC_BUSY = 2'b10
	} lcc_state_t;
endpackage
`default_nettype wire

// ===== design/lcc_range_pick.sv
// automatic range chooser: picks the lowest range that holds the sample
// assumes the sample is a raw linear light code in units of the finest lsb
`default_nettype none
module lcc_range_pick #(
	parameter int RAW_W = 23
) (
	// raw light level
	input wire logic [RAW_W-1:0] raw_in,
	// chosen exponent and mantissa
	output logic [3:0] exp_out,
	output logic [11:0] mant_out
);
	logic [3:0] pick;
	// smallest exponent whose shifted value fits in twelve bits
	always_comb begin
		pick = lcc_pkg::LCC_RANGE_MAX;
		for (int e = 11; e >= 0; e--) begin
			if ((raw_in >> e) < (RAW_W)'(4096))
				pick = 4'(e);
		end
	end
	assign exp_out = pick;
	assign mant_out = 12'(raw_in >> pick);
endmodule
`default_nettype wire

// ===== design/lcc_core.sv
// light conversion control: configuration register and conversion sequencer
// assumes a register port already decoded from the serial host link
// Functional notes
// - config write aborts running conversion
// - restart after write if mode needs it
// - range code matches result exponent encoding
// - code 1100b selects automatic range
// - auto range reported in result exponent
// - range field resets to 1100b
// - length bit: 0=100 ms, 1=800 ms
// - short time loses resolution on low ranges
// - result layout and lsb weight unchanged
// - mode 00 off, 01 single, 1x continuous
// - mode reads 01b during single conversion
// - single end clears mode to 00b
// - shutdown keeps flags and alert untouched
// - config register resets to c810h
// - done flag: set at end, cleared by a setup read or a non-shutdown write
`default_nettype none
module lcc_core #(
	parameter int SHORT_CYC = lcc_pkg::LCC_SHORT_CYC,
	parameter int LONG_CYC = lcc_pkg::LCC_LONG_CYC,
	parameter int RAW_W = 23
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic reset_in,
	// register port
	input wire logic [7:0] addr_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [15:0] wdata_in,
	output logic [15:0] rdata_out,
	// light sample and limit flags from the analog side
	input wire logic [RAW_W-1:0] raw_in,
	input wire logic overflow_in,
	input wire logic above_limit_marker_in,
	input wire logic below_limit_marker_in,
	input wire logic alert_in,
	// status
	output logic busy_out,
	output logic done_pulse_out,
	output logic [1:0] res_loss_out,
	output logic alert_out
);
	typedef struct packed {
		lcc_pkg::lcc_state_t state;
		logic [31:0] count;
		logic [15:0] setup;
		logic [15:0] result;
		logic [15:0] rdata;
		logic done_pulse;
		logic alert;
	} lcc_core_t;

	lcc_core_t s_reg, s_next;
	logic [3:0] auto_exp;
	logic [11:0] auto_mant;
	logic wr_setup, rd_setup, conv_end;
	logic [3:0] range_sel;
	logic [1:0] mode_sel;
	logic [31:0] conv_len;

	lcc_range_pick #(.RAW_W(RAW_W)) u_pick (
		.raw_in(raw_in),
		.exp_out(auto_exp),
		.mant_out(auto_mant)
	);

	////////////////////////////////////////////////////////////////////////
	// decode
	assign wr_setup = wr_in && (addr_in == lcc_pkg::LCC_ADDR_SETUP);
	assign rd_setup = rd_in && (addr_in == lcc_pkg::LCC_ADDR_SETUP);
	assign range_sel = s_reg.setup[lcc_pkg::LCC_RANGE_LSB +: 4];
	assign mode_sel = s_reg.setup[lcc_pkg::LCC_MODE_LSB +: 2];
	// length bit picks the conversion time
	assign conv_len = s_reg.setup[lcc_pkg::LCC_LEN_BIT] ? 32'(LONG_CYC) : 32'(SHORT_CYC);
	// a write in the end cycle wins: the finishing conversion is discarded
	assign conv_end = (s_reg.state == lcc_pkg::LCC_BUSY) && !wr_setup
		&& (s_reg.count >= conv_len - 32'h1);

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic [15:0] nw;
		nw = '0;
		s_next = s_reg;
		s_next.done_pulse = 1'b0;
		// flag bits follow the analog side at all times, shutdown included
		s_next.setup[lcc_pkg::LCC_ABOVE_BIT] = above_limit_marker_in;
		s_next.setup[lcc_pkg::LCC_BELOW_BIT] = below_limit_marker_in;
		s_next.alert = alert_in;
		// read of the setup register clears the done flag
		if (rd_setup)
			s_next.setup[lcc_pkg::LCC_DONE_BIT] = 1'b0;
		if (s_reg.state == lcc_pkg::LCC_BUSY)
			s_next.count = s_reg.count + 32'h1;
		if (conv_end) begin
			s_next.done_pulse = 1'b1;
			// same layout whatever the time; auto range puts its pick in exponent
			if (range_sel == lcc_pkg::LCC_RANGE_AUTO)
				s_next.result = {auto_exp, auto_mant};
			else // fixed range uses the code as exponent
				s_next.result = {range_sel, 12'(raw_in >> range_sel)};
			s_next.setup[lcc_pkg::LCC_OVF_BIT] = overflow_in;
			s_next.count = '0;
			if (mode_sel == lcc_pkg::LCC_MODE_SINGLE) begin
				// single shot returns to shutdown by itself
				s_next.setup[lcc_pkg::LCC_MODE_LSB +: 2] = lcc_pkg::LCC_MODE_OFF;
				s_next.state = lcc_pkg::LCC_IDLE;
			end
		end
		if (wr_setup) begin
			// only writable bits take the value
			nw = (wdata_in & lcc_pkg::LCC_RW_MASK) | (s_next.setup & ~lcc_pkg::LCC_RW_MASK);
			// non-shutdown write clears done; the end-cycle set is discarded with it
			if (wdata_in[lcc_pkg::LCC_MODE_LSB +: 2] != lcc_pkg::LCC_MODE_OFF)
				nw[lcc_pkg::LCC_DONE_BIT] = 1'b0;
			s_next.setup = nw;
			// abort and maybe restart
			s_next.count = '0;
			if (wdata_in[lcc_pkg::LCC_MODE_LSB +: 2] != lcc_pkg::LCC_MODE_OFF)
				s_next.state = lcc_pkg::LCC_BUSY;
			else
				s_next.state = lcc_pkg::LCC_IDLE;
		end else if (conv_end) begin
			// set wins over a read in the same cycle
			s_next.setup[lcc_pkg::LCC_DONE_BIT] = 1'b1;
		end
		// registered read data
		unique case (addr_in)
			lcc_pkg::LCC_ADDR_RESULT: s_next.rdata = s_reg.result;
			lcc_pkg::LCC_ADDR_SETUP: s_next.rdata = s_reg.setup; // mode stays 01 while a single conversion is busy
			default: s_next.rdata = '0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			s_reg.state <= lcc_pkg::LCC_IDLE;
			s_reg.count <= '0;
			s_reg.setup <= lcc_pkg::LCC_SETUP_RESET;
			s_reg.result <= '0;
			s_reg.rdata <= '0;
			s_reg.done_pulse <= 1'b0;
			s_reg.alert <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign rdata_out = s_reg.rdata;
	assign busy_out = (s_reg.state == lcc_pkg::LCC_BUSY);
	assign done_pulse_out = s_reg.done_pulse;
	assign alert_out = s_reg.alert;
	// resolution loss hint at the short time, fixed ranges only
	always_comb begin
		res_loss_out = 2'h0;
		if (!s_reg.setup[lcc_pkg::LCC_LEN_BIT] && range_sel <= lcc_pkg::LCC_RANGE_R5) begin
			if (range_sel == lcc_pkg::LCC_RANGE_R5)
				res_loss_out = lcc_pkg::LCC_LOSS_ONE;
			else if (range_sel == lcc_pkg::LCC_RANGE_R0)
				res_loss_out = lcc_pkg::LCC_LOSS_THREE;
			else
				res_loss_out = lcc_pkg::LCC_LOSS_TWO;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	a_write_aborts: assert property (@(posedge clock_in) disable iff (reset_in)
		wr_setup |=> s_reg.count == 32'h0 && !done_pulse_out)
		else $error("write did not abort conversion");
	a_write_restart: assert property (@(posedge clock_in) disable iff (reset_in)
		wr_setup |=> busy_out == ($past(wdata_in[10:9]) != 2'h0))
		else $error("restart after write wrong");
	a_auto_exp: assert property (@(posedge clock_in) disable iff (reset_in)
		conv_end && range_sel == lcc_pkg::LCC_RANGE_AUTO
		|=> s_reg.result[15:12] == $past(auto_exp))
		else $error("auto exponent not reported");
	a_fixed_exp: assert property (@(posedge clock_in) disable iff (reset_in)
		conv_end && range_sel != lcc_pkg::LCC_RANGE_AUTO
		|=> s_reg.result[15:12] == $past(range_sel))
		else $error("fixed exponent wrong");
	a_single_off: assert property (@(posedge clock_in) disable iff (reset_in)
		conv_end && mode_sel == 2'h1 |=> mode_sel == 2'h0 && !busy_out)
		else $error("single shot did not stop");
	a_single_holds: assert property (@(posedge clock_in) disable iff (reset_in)
		busy_out && mode_sel == 2'h1 && !conv_end && !wr_setup |=> mode_sel == 2'h1)
		else $error("mode changed during single shot");
	a_done_set: assert property (@(posedge clock_in) disable iff (reset_in)
		conv_end |=> s_reg.setup[7])
		else $error("done flag not set");
	a_ro_kept: assert property (@(posedge clock_in) disable iff (reset_in)
		wr_setup && !conv_end |=> s_reg.setup[8] == $past(s_reg.setup[8]))
		else $error("read-only bit written");
	a_off_keeps: assert property (@(posedge clock_in) disable iff (reset_in)
		wr_setup && wdata_in[10:9] == 2'h0 && !conv_end
		|=> s_reg.setup[7] == $past(s_reg.setup[7]))
		else $error("shutdown write changed done flag");
	// counter must never run past the length that the length bit selects
	a_len_select: assert property (@(posedge clock_in) disable iff (reset_in)
		busy_out |-> s_reg.count < (s_reg.setup[11] ? 32'(LONG_CYC) : 32'(SHORT_CYC)))
		else $error("conversion length wrong");
	a_cont_restart: assert property (@(posedge clock_in) disable iff (reset_in)
		conv_end && mode_sel[1] |=> busy_out && s_reg.count == 32'h0)
		else $error("continuous mode did not restart");
	a_loss_hint: assert property (@(posedge clock_in) disable iff (reset_in)
		s_reg.setup[lcc_pkg::LCC_LEN_BIT] |-> res_loss_out == 2'h0)
		else $error("loss hint shown at long time");
	// no disable here: this one watches the reset itself
	a_reset_value: assert property (@(posedge clock_in)
		reset_in |=> s_reg.setup == lcc_pkg::LCC_SETUP_RESET && !busy_out)
		else $error("setup register reset value wrong");
	c_single: cover property (@(posedge clock_in) conv_end && mode_sel == 2'h1);
	c_abort: cover property (@(posedge clock_in) wr_setup && busy_out);
	c_auto: cover property (@(posedge clock_in) conv_end && range_sel == 4'hc);
	c_continuous: cover property (@(posedge clock_in) conv_end && mode_sel[1]);
endmodule
`default_nettype wire

// ===== verif/lcc_host_model.sv
// host side model: writes and reads the decoded register port of the core
// assumes tasks are called by one bench process, inputs change at falling edges
`default_nettype none
module lcc_host_model (
	// clock and read data
	input wire logic clock_in,
	input wire logic [15:0] rdata_in,
	// register port
	output logic [7:0] addr_out,
	output logic wr_out,
	output logic rd_out,
	output logic [15:0] wdata_out
);
	timeunit 1ns;
	timeprecision 1ns;
	////////////////////////////////////////////////////////////////////////////
	// idle values at time zero
	initial begin
		addr_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
		wdata_out = 16'h0000;
	end
	// one-cycle write strobe; range codes 1101b-1111b are never issued
	task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
		@(negedge clock_in);
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(negedge clock_in);
		wr_out = 1'b0;
		wdata_out = ~d; // stale data must not look valid
	endtask
	// data is taken one cycle after the strobe edge
	task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
		@(negedge clock_in);
		addr_out = a;
		rd_out = 1'b1;
		@(negedge clock_in);
		rd_out = 1'b0;
		d = rdata_in;
	endtask
endmodule
`default_nettype wire

// ===== verif/lcc_core_tb_top.sv
// bench for the conversion control core with shortened conversion counts
// assumes the host model drives the register port, bench drives the analog side
`default_nettype none
module lcc_core_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SHORT = 10;
	localparam int LONG = 40;
	logic clock_in = 1'b0;
	logic reset_in = 1'b1;
	logic [22:0] raw = 23'h000064;
	logic ovf = 1'b0;
	logic above = 1'b0;
	logic below = 1'b0;
	logic alert = 1'b0;
	logic [7:0] addr;
	logic wr;
	logic rd;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic [15:0] got;
	logic busy;
	logic done;
	logic alert_q;
	logic [1:0] loss;
	int failures = 0;
	int check_count = 0;
	int n;
	////////////////////////////////////////////////////////////////////////////
	// clock and instances
	initial begin
		forever #10 clock_in = ~clock_in;
	end
	lcc_host_model u_lcc_host_model (.clock_in(clock_in), .rdata_in(rdata), .addr_out(addr),
		.wr_out(wr), .rd_out(rd), .wdata_out(wdata));
	lcc_core #(.SHORT_CYC(SHORT), .LONG_CYC(LONG), .RAW_W(23)) u_lcc_core (.clock_in(clock_in),
		.reset_in(reset_in), .addr_in(addr), .wr_in(wr), .rd_in(rd), .wdata_in(wdata),
		.rdata_out(rdata), .raw_in(raw), .overflow_in(ovf), .above_limit_marker_in(above),
		.below_limit_marker_in(below), .alert_in(alert), .busy_out(busy), .done_pulse_out(done),
		.res_loss_out(loss), .alert_out(alert_q));
	////////////////////////////////////////////////////////////////////////////
	// shared helpers
	task automatic check16(input logic [15:0] act, input logic [15:0] exp);
		check_count++;
		if (act !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, act, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// bounded wait for the end pulse, counting falling edges
	task automatic wait_end(output int cycles);
		cycles = 0;
		while (done !== 1'b1) begin
			@(negedge clock_in);
			cycles++;
			if (cycles > 1000) begin
				failures++;
				report_and_stop();
			end
		end
	endtask
	task automatic rd_setup(input logic [15:0] exp);
		u_lcc_host_model.read_reg(8'h01, got);
		check16(got, exp);
	endtask
	////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic test_reset();
		rd_setup(16'hc810);
		above = 1'b1;
		below = 1'b1;
		u_lcc_host_model.write_reg(8'h01, 16'h01e0);
		check16({14'h0, loss}, 16'h0003);
		rd_setup(16'h0060);
		above = 1'b0;
		below = 1'b0;
		u_lcc_host_model.write_reg(8'h00, 16'hffff);
		u_lcc_host_model.read_reg(8'h00, got);
		check16(got, 16'h0000);
		$display("test reset finished");
	endtask
	task automatic test_single_auto();
		u_lcc_host_model.write_reg(8'h01, 16'hca10);
		rd_setup(16'hca10);
		wait_end(n);
		// the read after the write uses two of the busy cycles
		check16(16'(n), 16'(LONG - 2));
		rd_setup(16'hc890);
		rd_setup(16'hc810);
		u_lcc_host_model.read_reg(8'h00, got);
		check16(got, 16'h0064);
		$display("test single auto finished");
	endtask
	task automatic test_fixed_short();
		raw = 23'h0022b0;
		ovf = 1'b1;
		u_lcc_host_model.write_reg(8'h01, 16'h3210);
		check16({14'h0, loss}, 16'h0002);
		wait_end(n);
		check16(16'(n), 16'(SHORT));
		u_lcc_host_model.read_reg(8'h00, got);
		check16(got, 16'h3456);
		ovf = 1'b0;
		$display("test fixed short finished");
	endtask
	task automatic test_abort();
		// done and overflow were left set; the write must clear done and keep overflow
		u_lcc_host_model.write_reg(8'h01, 16'hca10);
		rd_setup(16'hcb10);
		repeat (5) @(negedge clock_in);
		u_lcc_host_model.write_reg(8'h01, 16'hca10);
		wait_end(n);
		check16(16'(n), 16'(LONG));
		alert = 1'b1;
		u_lcc_host_model.write_reg(8'h01, 16'h0810);
		check16({15'h0, alert_q}, 16'h0001);
		rd_setup(16'h0890);
		u_lcc_host_model.write_reg(8'h01, 16'hca10);
		repeat (3) @(negedge clock_in);
		u_lcc_host_model.write_reg(8'h01, 16'hc810);
		check16({15'h0, busy}, 16'h0000);
		rd_setup(16'hc810);
		$display("test abort finished");
	endtask
	task automatic test_continuous();
		u_lcc_host_model.write_reg(8'h01, 16'h3410);
		wait_end(n);
		@(negedge clock_in);
		wait_end(n);
		// one cycle was spent stepping past the first end pulse
		check16(16'(n), 16'(SHORT - 1));
		rd_setup(16'h3490);
		u_lcc_host_model.write_reg(8'h01, 16'hc810);
		$display("test continuous finished");
	endtask
	// reset in mid conversion, mode 11 running
	task automatic test_mid_reset();
		u_lcc_host_model.write_reg(8'h01, 16'h3610);
		check16({15'h0, busy}, 16'h0001);
		repeat (3) @(negedge clock_in);
		reset_in = 1'b1;
		repeat (2) @(negedge clock_in);
		reset_in = 1'b0;
		check16({15'h0, busy}, 16'h0000);
		rd_setup(16'hc810);
		$display("test mid reset finished");
	endtask
	// main sequence: reset held for eight cycles, released at a falling edge
	initial begin
		repeat (8) @(posedge clock_in);
		@(negedge clock_in);
		reset_in = 1'b0;
		test_reset();
		test_single_auto();
		test_fixed_short();
		test_abort();
		test_continuous();
		test_mid_reset();
		report_and_stop();
	end
endmodule
`default_nettype wire
